// ==== scd_dma_chan.sv ====
// scd_dma_chan.sv - one dma channel move sequencer: read source, write
// destination, pad the move to its fixed length.
// assumes the top arbitrates access and keeps addresses and counts.
`timescale 1ns/1ps
`include "scd_params.svh"
module scd_dma_chan (
  input  wire logic clk,
  input  wire logic nrst,
  scd_dma_if.chan   dif
);
  import scd_pkg::*;

  localparam int MOVE_CYC = (`SCD_MOVE_OSC * `SCD_OSC_NS) / `SCD_CLK_NS;
  localparam logic [3:0] LAST = 4'(MOVE_CYC - 1);

  scd_state_type st_r;      // sequencer state
  scd_state_type st_nxt;
  logic [3:0]    tmr_r;     // cycles since move start
  logic [7:0]    byte_r;    // byte in flight

  // a move may start: go, bytes left, and request unless not demand mode
  wire start = dif.go && !dif.cnt_zero && (dif.dreq || !dif.demand);

  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SCD_IDLE: if (start) st_nxt = SCD_READ;
      SCD_READ: if (dif.acc_rvalid) st_nxt = SCD_WRIT;
      SCD_WRIT: if (dif.acc_gnt) st_nxt = SCD_HOLD;
      SCD_HOLD: if (tmr_r >= LAST) st_nxt = SCD_IDLE;
      default:  st_nxt = SCD_IDLE;
    endcase
  end

  // state, move timer and data holding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r   <= SCD_IDLE;
      tmr_r  <= 4'h0;
      byte_r <= 8'h00;
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= (st_r == SCD_IDLE) ? 4'h0 : tmr_r + 4'h1;
      if (st_r == SCD_READ && dif.acc_rvalid) byte_r <= dif.acc_rdata;
    end
  end

  // read request held until granted, then wait for data
  logic rd_pend_r;
  always_ff @(posedge clk) begin
    if (!nrst) rd_pend_r <= 1'b0;
    else if (st_r == SCD_IDLE) rd_pend_r <= 1'b1;
    else if (dif.acc_gnt) rd_pend_r <= 1'b0;
  end

  assign dif.acc_req   = (st_r == SCD_READ && rd_pend_r) || st_r == SCD_WRIT;
  assign dif.acc_we    = (st_r == SCD_WRIT);
  assign dif.acc_wdata = byte_r;
  assign dif.move_done = (st_r == SCD_HOLD) && (tmr_r >= LAST);
  assign dif.busy      = (st_r != SCD_IDLE);
endmodule // scd_dma_chan

// ==== scd_dma_if.sv ====
// scd_dma_if.sv - carrier between the service top and one dma channel.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface scd_dma_if;
  logic       go;         // channel started by software
  logic       demand;     // demand mode selected
  logic       dreq;       // serial fifo request, gated by dma bit
  logic       cnt_zero;   // byte count is zero
  logic       acc_gnt;    // access taken this cycle
  logic       acc_rvalid; // read data valid
  logic [7:0] acc_rdata;  // read data
  logic       acc_req;    // channel wants an access
  logic       acc_we;     // 1 write destination, 0 read source
  logic [7:0] acc_wdata;  // byte to write
  logic       move_done;  // one byte moved, pulse
  logic       busy;       // move in progress
  modport top (output go, demand, dreq, cnt_zero, acc_gnt, acc_rvalid, acc_rdata,
               input acc_req, acc_we, acc_wdata, move_done, busy);
  modport chan (input go, demand, dreq, cnt_zero, acc_gnt, acc_rvalid, acc_rdata,
                output acc_req, acc_we, acc_wdata, move_done, busy);
endinterface // scd_dma_if

// ==== scd_link_model.sv ====
// scd_link_model.sv - serial fifos and line behind scd_top.
// assumes clk is the block clock; the bench calls its tasks.
`timescale 1ns/1ps
module scd_link_model (
  input  wire logic       clk,
  input  wire logic       txf_push_r,
  input  wire logic [7:0] txf_data_r,
  input  wire logic       rxf_pop_r,
  output logic            txf_req,
  output logic            txf_empty,
  output logic            tx_last_bit,
  output logic            tx_busy,
  output logic      [7:0] rxf_data,
  output logic            rxf_not_empty,
  output logic            rx_eof,
  output logic            rx_busy
);
  logic [7:0] rxq[$];         // rx fifo
  logic [7:0] txlog[$];       // pushed bytes
  int         want = 0;       // bytes wanted
  int         fill = 0;       // bytes queued
  int         tick = 0;       // drain pacing
  logic       tx_hold = 1'b0; // keeps transmitter busy
  // quiet outputs at time zero
  initial {tx_last_bit, rx_eof, rx_busy, rxf_not_empty, rxf_data} = 12'h05A;
  assign txf_empty = (fill == 0);
  assign tx_busy   = (fill != 0) || tx_hold;
  assign txf_req   = (want > 0) && (fill < 4);
  // fifo and line on each edge
  always @(posedge clk) begin
    tx_last_bit <= 1'b0;
    tick <= (tick + 1) % 64;
    if (txf_push_r) begin
      txlog.push_back(txf_data_r);
      fill <= fill + 1;
      want <= want - 1;
    end else if (tick == 63 && fill > 0) begin
      fill <= fill - 1;
      tx_last_bit <= (fill == 1);
    end
    if (rxf_pop_r && rxq.size() > 0)
      void'(rxq.pop_front());
    rxf_not_empty <= (rxq.size() != 0);
    rxf_data <= (rxq.size() != 0) ? rxq[0] : ~rxf_data; // no stale head
  end
  task automatic push_rx(input logic [7:0] b);
    rxq.push_back(b);
    rx_busy <= 1'b1;
  endtask
  task automatic end_frame();
    @(posedge clk);
    rx_eof <= 1'b1;
    rx_busy <= 1'b0;
    @(posedge clk);
    rx_eof <= 1'b0;
  endtask
endmodule // scd_link_model

// ==== scd_params.svh ====
// scd_params.svh - offsets, field positions, reset values and timing counts
// for the serial channel dma service block; included by the design files.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// fifo ports in sfr space
`define SCD_SERIAL_TX_FIFO_PORT_ADR     8'h85
`define SCD_RECEIVE_FIFO_PORT_ADR     8'hF4
// control and status registers in sfr space
`define SCD_TRANSMIT_STATUS_REGISTER_ADR     8'hD8
`define SCD_MODE_ADR      8'hD9
`define SCD_SPACE_ADR     8'hDA
`define SCD_CH0_BASE      8'hC0
`define SCD_CH1_BASE      8'hC8
// per-channel register offsets from the channel base
`define SCD_OFS_CTL       8'h00
`define SCD_OFS_SRCL      8'h01
`define SCD_OFS_SRCH      8'h02
`define SCD_OFS_DSTL      8'h03
`define SCD_OFS_DSTH      8'h04
`define SCD_OFS_CNTL      8'h05
`define SCD_OFS_CNTH      8'h06
// channel control fields
`define SCD_CTL_GO        0
`define SCD_CTL_DONE      1
`define SCD_CTL_XMODE     2
`define SCD_CTL_DEMAND    3
`define SCD_CTL_SRC_INC   4
`define SCD_CTL_SRC_SFR   5
`define SCD_CTL_DST_INC   6
`define SCD_CTL_DST_SFR   7
// transmit status fields
`define SCD_TS_DMA        0
`define SCD_TS_TXDONE     1
`define SCD_TS_RXDONE     2
`define SCD_TS_RECEIVE_FIFO_NOT_EMPTY       3
// mode fields
`define SCD_MD_CRC32      0
`define SCD_MD_HALF       1
`define SCD_MD_RXEN       2
`define SCD_MD_TXEN       3
`define SCD_MD_AREN       4
// reset values, broadcast address
`define SCD_CTL_RST       8'h00
`define SCD_MODE_RST      8'h00
`define SCD_SPACE_RST     4'h0
`define SCD_BCAST_ADR     8'hFF
// timing: oscillator periods per dma move, clock period in ns
`define SCD_MOVE_OSC      12
`define SCD_OSC_NS        4
`define SCD_CLK_NS        4

`endif

// ==== scd_pkg.sv ====
// scd_pkg.sv - types shared by the serial channel dma service modules.
// assumes nothing beyond a systemverilog compiler.
package scd_pkg;
  // dma move sequencer, gray along idle-read-write-hold
  typedef enum logic [1:0] {
    SCD_IDLE = 2'b00,
    SCD_READ = 2'b01,
    SCD_WRIT = 2'b11,
    SCD_HOLD = 2'b10
  } scd_state_type;
  // memory space of one access
  typedef enum logic [1:0] {
    SCD_SP_INT = 2'b00,
    SCD_SP_EXT = 2'b01,
    SCD_SP_SFR = 2'b10
  } scd_space_type;
endpackage

// ==== scd_top.sv ====
// scd_top.sv - duplex selection and dma servicing of the serial channel:
// sfr registers, two dma channels, fifo access, done flags.
// assumes the cpu sfr port, a one-cycle data memory and the serial fifos
// are synchronous to clk.
`timescale 1ns/1ps
`include "scd_params.svh"
module scd_top (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            sfr_addr,       // cpu sfr address
  input  wire logic                  sfr_we,         // cpu sfr write strobe
  input  wire logic                  sfr_re,         // cpu sfr read strobe
  input  wire logic [7:0]            sfr_wdata,      // cpu sfr write data
  output logic      [7:0]            sfr_rdata_r,    // cpu sfr read data
  output logic                       mem_req_r,      // data memory access
  output logic                       mem_we_r,       // data memory write
  output scd_pkg::scd_space_type     mem_space_r,    // internal or external
  output logic      [15:0]           mem_addr_r,     // data memory address
  output logic      [7:0]            mem_wdata_r,    // data memory write data
  input  wire logic [7:0]            mem_rdata,      // data, one cycle later
  output logic                       txf_push_r,     // transmit fifo write
  output logic      [7:0]            txf_data_r,     // transmit fifo byte
  input  wire logic                  txf_req,        // transmit fifo wants data
  input  wire logic                  txf_empty,      // transmit fifo empty
  input  wire logic                  tx_last_bit,    // final bit left, pulse
  input  wire logic                  tx_busy,        // transmitter sending
  output logic                       rxf_pop_r,      // receive fifo read
  input  wire logic [7:0]            rxf_data,       // receive fifo head
  input  wire logic                  rxf_not_empty,  // receive fifo holds data
  input  wire logic                  rx_eof,         // end of frame seen, pulse
  input  wire logic                  rx_busy,        // receiver in a frame
  input  wire logic [7:0]            station_addr,   // own station address
  input  wire logic [7:0]            addr_mask,      // address mask
  input  wire logic [7:0]            tx_frame_addr,  // address being sent
  output logic                       full_duplex_r,  // full duplex in force
  output logic                       crc_split_r,    // 32-bit crc runs as 16-bit
  output logic                       rx_active_r,    // receiver may run
  output logic                       tx_active_r,    // transmitter may run
  output logic                       self_rx_r,      // own frame will be received
  output logic      [1:0]            dma_done_r      // channel done flags
);
  import scd_pkg::*;

  // registers
  logic [7:0]  mode_r;        // crc, half duplex, enables
  logic [3:0]  space_r;       // {ch1 dst ext, ch1 src ext, ch0 dst ext, ch0 src ext}
  logic        dma_sel_r;     // status bit: dma services channel
  logic        tx_done_r;     // transmit done flag
  logic        rx_done_r;     // receive done flag
  logic [7:0]  ctl_r  [2];    // channel control, done bit kept apart
  logic [7:0]  srcl_r [2];
  logic [7:0]  srch_r [2];
  logic [7:0]  dstl_r [2];
  logic [7:0]  dsth_r [2];
  logic [15:0] cnt_r  [2];    // byte counts up to 64K

  scd_dma_if dif [2] ();

  // access pipeline
  logic        a1_v_r, a1_we_r, a1_own_r;  // stage one: issued access
  scd_space_type a1_sp_r;
  logic        a1_receive_fifo_port_r;
  logic [7:0]  a1_sfr_r;                    // sfr byte read at stage one
  logic        a2_v_r, a2_own_r, a2_mem_r;  // stage two: data back
  logic [7:0]  hold_r;

  // base address of a channel's register group
  function automatic logic [7:0] ch_base(input int i);
    return (i == 0) ? `SCD_CH0_BASE : `SCD_CH1_BASE;
  endfunction

  // sfr read decode, shared by cpu and dma
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `SCD_TRANSMIT_STATUS_REGISTER_ADR) r = {4'h0, rxf_not_empty, rx_done_r, tx_done_r, dma_sel_r};
    else if (a == `SCD_MODE_ADR) r = mode_r;
    else if (a == `SCD_SPACE_ADR) r = {4'h0, space_r};
    else if (a == `SCD_RECEIVE_FIFO_PORT_ADR) r = rxf_data;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (a == ch_base(i) + `SCD_OFS_CTL) r = {ctl_r[i][7:2], dma_done_r[i], ctl_r[i][0]};
        else if (a == ch_base(i) + `SCD_OFS_SRCL) r = srcl_r[i];
        else if (a == ch_base(i) + `SCD_OFS_SRCH) r = srch_r[i];
        else if (a == ch_base(i) + `SCD_OFS_DSTL) r = dstl_r[i];
        else if (a == ch_base(i) + `SCD_OFS_DSTH) r = dsth_r[i];
        else if (a == ch_base(i) + `SCD_OFS_CNTL) r = cnt_r[i][7:0];
        else if (a == ch_base(i) + `SCD_OFS_CNTH) r = cnt_r[i][15:8];
      end
    end
    return r;
  endfunction

  // arbitration: channel 0 first, one access per cycle
  wire       g0    = dif[0].acc_req;
  wire       g1    = dif[1].acc_req && !g0;
  wire       gv    = g0 || g1;
  wire       gown  = g1;
  wire       gwe   = g1 ? dif[1].acc_we : dif[0].acc_we;
  wire [7:0] gwdat = g1 ? dif[1].acc_wdata : dif[0].acc_wdata;
  wire [7:0] gctl  = g1 ? ctl_r[1] : ctl_r[0];
  wire       gsfr  = gwe ? gctl[`SCD_CTL_DST_SFR] : gctl[`SCD_CTL_SRC_SFR];
  wire       gext  = gwe ? space_r[{gown, 1'b1}] : space_r[{gown, 1'b0}];
  wire [7:0] glo   = gwe ? (g1 ? dstl_r[1] : dstl_r[0]) : (g1 ? srcl_r[1] : srcl_r[0]);
  wire [7:0] ghi   = gwe ? (g1 ? dsth_r[1] : dsth_r[0]) : (g1 ? srch_r[1] : srch_r[0]);
  wire [15:0] gadr = gsfr ? {8'h00, glo} : {ghi, glo};
  wire scd_space_type gsp = gsfr ? SCD_SP_SFR : (gext ? SCD_SP_EXT : SCD_SP_INT);

  // unified sfr write: cpu first, then a dma write into sfr space
  wire       dma_sfr_w = a1_v_r && a1_we_r && a1_sp_r == SCD_SP_SFR && !sfr_we;
  wire       w_en  = sfr_we || dma_sfr_w;
  wire [7:0] w_adr = sfr_we ? sfr_addr : mem_addr_r[7:0];
  wire [7:0] w_dat = sfr_we ? sfr_wdata : mem_wdata_r;

  // duplex selection
  wire crc32   = mode_r[`SCD_MD_CRC32];
  wire full_dx = !crc32 && !mode_r[`SCD_MD_HALF];
  wire self_hit = tx_frame_addr == `SCD_BCAST_ADR || addr_mask == 8'hFF ||
                  (tx_frame_addr & addr_mask) == (station_addr & addr_mask);
  wire self_rx = !full_dx && mode_r[`SCD_MD_RXEN] && tx_busy &&
                 (!mode_r[`SCD_MD_AREN] || self_hit);

  // mode, space and status registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_r    <= `SCD_MODE_RST;
      space_r   <= `SCD_SPACE_RST;
      dma_sel_r <= 1'b0;
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      if (w_en && w_adr == `SCD_MODE_ADR) begin
        mode_r <= w_dat;
        // dropping to 16-bit crc returns to full duplex
        if (crc32 && !w_dat[`SCD_MD_CRC32]) mode_r[`SCD_MD_HALF] <= 1'b0;
      end
      if (w_en && w_adr == `SCD_SPACE_ADR) space_r <= w_dat[3:0];
      if (w_en && w_adr == `SCD_TRANSMIT_STATUS_REGISTER_ADR) dma_sel_r <= w_dat[`SCD_TS_DMA];
      // flags: write 0 clears, hardware set wins
      tx_done_r <= (txf_empty && tx_last_bit) ||
                   (tx_done_r && !(w_en && w_adr == `SCD_TRANSMIT_STATUS_REGISTER_ADR && !w_dat[`SCD_TS_TXDONE]));
      rx_done_r <= rx_eof ||
                   (rx_done_r && !(w_en && w_adr == `SCD_TRANSMIT_STATUS_REGISTER_ADR && !w_dat[`SCD_TS_RXDONE]));
    end
  end

  // duplex and activity outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      full_duplex_r <= 1'b0;
      crc_split_r   <= 1'b0;
      rx_active_r   <= 1'b0;
      tx_active_r   <= 1'b0;
      self_rx_r     <= 1'b0;
    end else begin
      full_duplex_r <= full_dx;
      crc_split_r   <= full_dx;
      rx_active_r   <= mode_r[`SCD_MD_RXEN] && (full_dx || !tx_busy || self_rx);
      tx_active_r   <= mode_r[`SCD_MD_TXEN] && (full_dx || !rx_busy);
      self_rx_r     <= self_rx;
    end
  end

  // per-channel registers and sequencers
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire [7:0] base  = ch_base(i);
    wire       mdone = dif[i].move_done;
    wire       last  = mdone && cnt_r[i] == 16'h0001;
    wire       wc    = w_en && w_adr == base + `SCD_OFS_CTL;

    // channel 0 follows the receiver, channel 1 the transmitter
    assign dif[i].go         = ctl_r[i][`SCD_CTL_GO];
    assign dif[i].demand     = ctl_r[i][`SCD_CTL_DEMAND];
    assign dif[i].dreq       = dma_sel_r && ((i == 0) ? rxf_not_empty : txf_req);
    assign dif[i].cnt_zero   = cnt_r[i] == 16'h0000;
    assign dif[i].acc_gnt    = (i == 0) ? g0 : g1;
    assign dif[i].acc_rvalid = a2_v_r && a2_own_r == 1'(i);
    assign dif[i].acc_rdata  = a2_mem_r ? mem_rdata : hold_r;

    scd_dma_chan u_chan (
      .clk  (clk),
      .nrst (nrst),
      .dif  (dif[i])
    );

    // control, addresses, count
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ctl_r[i]      <= `SCD_CTL_RST;
        dma_done_r[i] <= 1'b0;
        srcl_r[i]     <= 8'h00;
        srch_r[i]     <= 8'h00;
        dstl_r[i]     <= 8'h00;
        dsth_r[i]     <= 8'h00;
        cnt_r[i]      <= 16'h0000;
      end else begin
        if (wc) ctl_r[i] <= w_dat;
        if (last) ctl_r[i][`SCD_CTL_GO] <= 1'b0;
        dma_done_r[i] <= last || (dma_done_r[i] && !(wc && !w_dat[`SCD_CTL_DONE]));
        if (w_en && w_adr == base + `SCD_OFS_SRCL) srcl_r[i] <= w_dat;
        else if (mdone && ctl_r[i][`SCD_CTL_SRC_INC]) {srch_r[i], srcl_r[i]} <= {srch_r[i], srcl_r[i]} + 16'h0001;
        if (w_en && w_adr == base + `SCD_OFS_SRCH) srch_r[i] <= w_dat;
        if (w_en && w_adr == base + `SCD_OFS_DSTL) dstl_r[i] <= w_dat;
        else if (mdone && ctl_r[i][`SCD_CTL_DST_INC]) {dsth_r[i], dstl_r[i]} <= {dsth_r[i], dstl_r[i]} + 16'h0001;
        if (w_en && w_adr == base + `SCD_OFS_DSTH) dsth_r[i] <= w_dat;
        // one count per transfer, counted down per byte
        if (w_en && w_adr == base + `SCD_OFS_CNTL) cnt_r[i][7:0] <= w_dat;
        else if (w_en && w_adr == base + `SCD_OFS_CNTH) cnt_r[i][15:8] <= w_dat;
        else if (mdone && cnt_r[i] != 16'h0000) cnt_r[i] <= cnt_r[i] - 16'h0001;
      end
    end
  end

  // stage one: drive memory or fifo ports from the granted access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      a1_v_r <= 1'b0; a1_we_r <= 1'b0; a1_own_r <= 1'b0; a1_sp_r <= SCD_SP_INT;
      a1_receive_fifo_port_r <= 1'b0;
      mem_req_r <= 1'b0; mem_we_r <= 1'b0; mem_space_r <= SCD_SP_INT;
      mem_addr_r <= 16'h0000; mem_wdata_r <= 8'h00;
      txf_push_r <= 1'b0; txf_data_r <= 8'h00; rxf_pop_r <= 1'b0;
    end else begin
      a1_v_r      <= gv;
      a1_we_r     <= gwe;
      a1_own_r    <= gown;
      a1_sp_r     <= gsp;
      a1_receive_fifo_port_r  <= gv && !gwe && gsp == SCD_SP_SFR && gadr[7:0] == `SCD_RECEIVE_FIFO_PORT_ADR;
      mem_req_r   <= gv && gsp != SCD_SP_SFR;
      mem_we_r    <= gwe;
      mem_space_r <= gsp;
      mem_addr_r  <= gadr;
      mem_wdata_r <= gwdat;
      txf_push_r  <= gv && gwe && gsp == SCD_SP_SFR && gadr[7:0] == `SCD_SERIAL_TX_FIFO_PORT_ADR;
      txf_data_r  <= gwdat;
      rxf_pop_r   <= gv && !gwe && gsp == SCD_SP_SFR && gadr[7:0] == `SCD_RECEIVE_FIFO_PORT_ADR;
    end
  end

  assign a1_sfr_r = sfr_read(mem_addr_r[7:0]);

  // stage two: read data back to the owning channel
  always_ff @(posedge clk) begin
    if (!nrst) begin
      a2_v_r <= 1'b0; a2_own_r <= 1'b0; a2_mem_r <= 1'b0; hold_r <= 8'h00;
    end else begin
      a2_v_r   <= a1_v_r && !a1_we_r;
      a2_own_r <= a1_own_r;
      a2_mem_r <= a1_sp_r != SCD_SP_SFR;
      hold_r   <= a1_receive_fifo_port_r ? rxf_data : a1_sfr_r;
    end
  end

  // cpu read data
  always_ff @(posedge clk) begin
    if (!nrst) sfr_rdata_r <= 8'h00;
    else if (sfr_re) sfr_rdata_r <= sfr_read(sfr_addr);
  end
endmodule // scd_top

// ==== scd_top_chk.sv ====
// scd_top_chk.sv - port assertions and covers for scd_top.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module scd_top_chk
  import scd_pkg::*;
(
  input logic                  clk,
  input logic                  nrst,
  input logic [7:0]            sfr_addr,
  input logic                  sfr_we,
  input logic                  sfr_re,
  input logic [7:0]            sfr_wdata,
  input logic [7:0]            sfr_rdata_r,
  input logic                  mem_req_r,
  input scd_pkg::scd_space_type mem_space_r,
  input logic                  txf_push_r,
  input logic                  rxf_pop_r,
  input logic [7:0]            rxf_data,
  input logic                  rxf_not_empty,
  input logic                  tx_busy,
  input logic                  full_duplex_r,
  input logic                  crc_split_r,
  input logic                  rx_active_r,
  input logic                  self_rx_r,
  input logic [1:0]            dma_done_r
);
  // one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // mode writes decide duplex two edges on
  a_crc16_full: assert property (sfr_we && sfr_addr == 8'hD9 && sfr_wdata[1:0] == 2'b00 |-> ##2 full_duplex_r)
    else $error("crc16 not full");
  a_split_full: assert property (full_duplex_r |-> crc_split_r) else $error("crc not split");
  a_crc32_half: assert property (sfr_we && sfr_addr == 8'hD9 && sfr_wdata[0] |-> ##2 !full_duplex_r)
    else $error("crc32 in full");
  // half duplex: rx off while sending, unless own frame is received
  a_half_one_dir: assert property (!full_duplex_r && $past(tx_busy) && !self_rx_r |-> !rx_active_r)
    else $error("rx on in send");
  a_self_rx_half: assert property (self_rx_r |-> !full_duplex_r && $past(tx_busy)) else $error("bad self rx");
  // a move spans at least twelve cycles
  a_rx_spacing: assert property (rxf_pop_r |=> (!rxf_pop_r) [*8] ##1 (!rxf_pop_r) [*3])
    else $error("pops close");
  a_tx_spacing: assert property (txf_push_r |=> (!txf_push_r) [*8] ##1 (!txf_push_r) [*3])
    else $error("pushes close");
  a_pop_on_req: assert property (rxf_pop_r |-> rxf_not_empty) else $error("pop empty");
  a_done_holds: assert property (dma_done_r[0] && !(sfr_we && sfr_addr == 8'hC0) |=> dma_done_r[0])
    else $error("done dropped");
  a_fifo_peek: assert property (sfr_re && sfr_addr == 8'hF4 |=> sfr_rdata_r == $past(rxf_data))
    else $error("fifo peek");
  a_mem_space: assert property (mem_req_r |-> mem_space_r != SCD_SP_SFR) else $error("mem in sfr");
  // main scenarios reached
  c_full: cover property (full_duplex_r);
  c_self: cover property (self_rx_r);
  c_rx_done: cover property ($rose(dma_done_r[0]));
  c_tx_done: cover property ($rose(dma_done_r[1]));
endmodule // scd_top_chk

bind scd_top scd_top_chk u_chk (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_re(sfr_re),
  .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .mem_req_r(mem_req_r), .mem_space_r(mem_space_r),
  .txf_push_r(txf_push_r), .rxf_pop_r(rxf_pop_r), .rxf_data(rxf_data), .rxf_not_empty(rxf_not_empty),
  .tx_busy(tx_busy), .full_duplex_r(full_duplex_r), .crc_split_r(crc_split_r), .rx_active_r(rx_active_r),
  .self_rx_r(self_rx_r), .dma_done_r(dma_done_r));

// ==== serial_channel_dma_service_tb.sv ====
// serial_channel_dma_service_tb.sv - self-checking bench for scd_top.
// assumes scd_pkg, scd_link_model and scd_top_chk are compiled first.
`timescale 1ns/1ps
module serial_channel_dma_service_tb;
  import scd_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, sfr_we = 1'b0, sfr_re = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, mem_rdata = 8'h00;
  logic [7:0] station_addr = 8'h00, addr_mask = 8'h00, tx_frame_addr = 8'h00;
  logic [7:0] sfr_rdata_r, mem_wdata_r, txf_data_r, rxf_data, mem [0:255];
  logic [15:0] mem_addr_r;
  logic [1:0] dma_done_r;
  logic       mem_req_r, mem_we_r, txf_push_r, rxf_pop_r, full_duplex_r, crc_split_r;
  logic       rx_active_r, tx_active_r, self_rx_r, txf_req, txf_empty, tx_last_bit;
  logic       tx_busy, rxf_not_empty, rx_eof, rx_busy;
  scd_space_type mem_space_r;
  logic [31:0] seed = 32'h724DAD77; // lfsr state
  int         fail_count = 0, checks_done = 0, cyc = 0, nmem = 0;
  scd_top dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
    .mem_space_r(mem_space_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata),
    .txf_push_r(txf_push_r), .txf_data_r(txf_data_r), .txf_req(txf_req), .txf_empty(txf_empty),
    .tx_last_bit(tx_last_bit), .tx_busy(tx_busy), .rxf_pop_r(rxf_pop_r), .rxf_data(rxf_data),
    .rxf_not_empty(rxf_not_empty), .rx_eof(rx_eof), .rx_busy(rx_busy), .station_addr(station_addr),
    .addr_mask(addr_mask), .tx_frame_addr(tx_frame_addr), .full_duplex_r(full_duplex_r),
    .crc_split_r(crc_split_r), .rx_active_r(rx_active_r), .tx_active_r(tx_active_r),
    .self_rx_r(self_rx_r), .dma_done_r(dma_done_r));
  scd_link_model link (.clk(clk), .txf_push_r(txf_push_r), .txf_data_r(txf_data_r), .rxf_pop_r(rxf_pop_r),
    .txf_req(txf_req), .txf_empty(txf_empty), .tx_last_bit(tx_last_bit), .tx_busy(tx_busy),
    .rxf_data(rxf_data), .rxf_not_empty(rxf_not_empty), .rx_eof(rx_eof), .rx_busy(rx_busy));
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  // one-cycle data memory, changing data when idle
  always @(posedge clk) begin
    if (mem_req_r && mem_we_r)
      mem[mem_addr_r[7:0]] = mem_wdata_r;
    mem_rdata <= (mem_req_r && !mem_we_r) ? mem[mem_addr_r[7:0]] : ~mem_rdata;
  end
  // cycle ceiling and access count
  always @(posedge clk) begin
    cyc++;
    if (mem_req_r === 1'b1)
      nmem++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // cpu bus cycles, launched at an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge clk);
    sfr_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_re <= 1'b1;
    @(posedge clk);
    sfr_re <= 1'b0;
    #1 d = sfr_rdata_r;
  endtask
  task automatic wr_chan(input logic [7:0] base, input logic [7:0] v[6]);
    for (int i = 0; i < 6; i++)
      wr(base + 8'(i + 1), v[i]);
  endtask
  task automatic wait_done(input int ch);
    for (int i = 0; i < 300 && dma_done_r[ch] !== 1'b1; i++)
      @(posedge clk);
    #1 cmp("done flag", 8'h01, 8'(dma_done_r[ch]));
  endtask
  // main sequence
  initial begin
    logic [7:0] d, b, sa, ta, mk;
    logic [7:0] rxe[$], txe[$];
    logic [7:0] seq[5] = '{8'h00, 8'h02, 8'h01, 8'h02, 8'h03};
    logic [7:0] rst_adr[5] = '{8'hD8, 8'hD9, 8'hC0, 8'hC8, 8'h00};
    logic pc = 1'b0, ex;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_adr[i]) begin
      rd(rst_adr[i], d);
      cmp("reset read", 8'h00, d);
    end
    $display("test reset done");
    foreach (seq[k]) begin
      wr(8'hD9, 8'h0C | seq[k]);
      #9;
      ex = !seq[k][0] && !(seq[k][1] && !pc);
      pc = seq[k][0];
      cmp("full duplex", 8'(ex), 8'(full_duplex_r));
      cmp("tx active", 8'h01, 8'(tx_active_r));
    end
    $display("test duplex done");
    wr(8'hD9, 8'h1F);
    link.tx_hold <= 1'b1;
    sa = rnd() & 8'h7E;
    for (int k = 0; k < 5; k++) begin
      ta = (k % 4 == 0) ? 8'hFF : (k == 2) ? (sa ^ 8'h01) : (sa ^ 8'h10);
      mk = (k == 1) ? 8'hFF : 8'hF0;
      if (k == 4) wr(8'hD9, 8'h0B);
      @(posedge clk);
      station_addr <= sa;
      tx_frame_addr <= ta;
      addr_mask <= mk;
      #9;
      cmp("self rx", 8'(k < 3), 8'(self_rx_r));
      cmp("rx gated", 8'(k < 3), 8'(rx_active_r));
    end
    link.tx_hold <= 1'b0;
    $display("test self rx done");
    wr(8'hD9, 8'h0C);
    wr(8'hDA, 8'h00);
    wr(8'hD8, 8'h01);
    wr_chan(8'hC0, '{8'hF4, rnd(), 8'h20, 8'h00, 8'h03, 8'h00});
    wr(8'hC0, 8'h69);
    repeat (30) @(posedge clk);
    cmp("idle moves", 8'h00, 8'(nmem));
    for (int i = 0; i < 4; i++) begin
      b = rnd();
      link.push_rx(b);
      if (i < 3)
        rxe.push_back(b);
    end
    link.end_frame();
    wait_done(0);
    foreach (rxe[i]) cmp("rx byte", rxe[i], mem[8'h20 + 8'(i)]);
    cmp("receive_fifo_not_empty", 8'h01, 8'(rxf_not_empty));
    rd(8'hF4, d);
    cmp("fifo head", b, d);
    rd(8'hD8, d);
    cmp("status", 8'h0D, d);
    $display("test rx dma done");
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      mem[8'h40 + 8'(i)] = b;
      txe.push_back(b);
    end
    wr_chan(8'hC8, '{8'h40, 8'h00, 8'h85, rnd(), 8'h03, 8'h00});
    link.want <= 5;
    wr(8'hC8, 8'h99);
    wait_done(1);
    cmp("pushes", 8'h03, 8'(link.txlog.size()));
    foreach (txe[i]) cmp("tx byte", txe[i], link.txlog[i]);
    rd(8'hD8, d);
    cmp("tx done early", 8'h00, 8'(d[1]));
    for (int i = 0; i < 100 && d[1] !== 1'b1; i++)
      rd(8'hD8, d);
    cmp("tx done", 8'h01, 8'(d[1]));
    cmp("tx empty", 8'h01, 8'(txf_empty));
    $display("test tx dma done");
    close_out();
  end
endmodule // serial_channel_dma_service_tb
